//--- rtl/emb_port.v
// External parallel bus port: master accesses, slave register access,
// suspend handling and SDRAM command pins.
// Assumes bus arbitration and SDRAM sequencing are done elsewhere.
`include "emb_defines.vh"

module emb_port
#(
  parameter LEN_W = `EMB_LEN_W
)
(
  // Clock and reset
  input  wire                     sys_clk,
  input  wire                     resetn,
  // Core access request
  input  wire                     acc_start,
  input  wire                     acc_write,
  input  wire                     acc_sync,
  input  wire                     acc_sdram,
  input  wire [`EMB_WADDR_W-1:0]  acc_addr,
  input  wire [LEN_W-1:0]         acc_len,
  input  wire [`EMB_DATA_W-1:0]   acc_wdata,
  output reg                      acc_busy_q,
  output reg                      word_take_q,
  output reg                      rdata_valid_q,
  output reg  [`EMB_DATA_W-1:0]   rdata_q,
  output reg                      acc_done_q,
  // Configuration
  input  wire                     is_bus_master,
  input  wire                     link_ports_off,
  input  wire [1:0]               instr_packing_field,
  // SDRAM command
  input  wire                     sd_cmd_valid,
  input  wire [2:0]               sd_cmd,
  input  wire                     sd_a10,
  output reg                      sd_ras_n_q,
  output reg                      sd_cas_n_q,
  output reg                      sd_we_n_q,
  output reg                      sdram_addr_bit_ten_q,
  output reg                      sdclk_q,
  // Address and data pins
  input  wire [`EMB_ADDR_W-1:0]   addr_i,
  output reg  [`EMB_ADDR_W-1:0]   addr_o_q,
  output reg                      addr_oe_n_q,
  input  wire [`EMB_DATA_W-1:0]   data_i,
  output reg  [`EMB_DATA_W-1:0]   data_o_q,
  output reg                      data_hi_oe_n_q,
  output reg                      data_lo_oe_n_q,
  // Bank selects
  output reg  [3:0]               memory_bank_select_n_q,
  output reg                      ms_oe_n_q,
  // Strobes, burst and acknowledge
  input  wire                     rd_n_i,
  output reg                      rd_n_o_q,
  output reg                      rd_n_oe_n_q,
  input  wire                     wr_n_i,
  output reg                      wr_n_o_q,
  output reg                      wr_n_oe_n_q,
  input  wire                     burst_indicator_i,
  output reg                      burst_indicator_o_q,
  output reg                      burst_indicator_oe_n_q,
  input  wire                     ack_i,
  output reg                      ack_o_q,
  output reg                      ack_oe_n_q,
  // Suspend
  input  wire                     suspend_bus_tristate_n
);

  localparam SYW = `EMB_ADDR_W + `EMB_DATA_W + 5;
  localparam IAW = `EMB_IOP_AW;

  localparam M_IDLE  = 2'b01;
  localparam M_ACC   = 2'b10;
  localparam S_IDLE  = 3'b001;
  localparam S_WAIT  = 3'b010;
  localparam S_DRIVE = 3'b100;

  // ===================================================================
  // Pin synchronisers
  // ===================================================================
  reg  [SYW-1:0] sy1_q;
  reg  [SYW-1:0] sy2_q;
  wire [`EMB_ADDR_W-1:0] addr_s;
  wire [`EMB_DATA_W-1:0] data_s;
  wire           rd_s;
  wire           wr_s;
  wire           burst_indicator_s;
  wire           ack_s;
  wire           suspend_bus_tristate_n_s;

  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      sy1_q <= {SYW{1'b1}};
      sy2_q <= {SYW{1'b1}};
    end
    else
    begin
      sy1_q <= {addr_i, data_i, rd_n_i, wr_n_i, burst_indicator_i, ack_i,
                suspend_bus_tristate_n};
      sy2_q <= sy1_q;
    end
  end

  assign {addr_s, data_s, rd_s, wr_s, burst_indicator_s, ack_s, suspend_bus_tristate_n_s} = sy2_q;

  // ===================================================================
  // Width selection and bank decode
  // ===================================================================
  wire full_w = link_ports_off & (instr_packing_field == `EMB_PACK_FULL);
  wire [1:0] bank = acc_sdram ? acc_addr[`EMB_BANK_LSB_SDR +: 2]
                              : acc_addr[`EMB_BANK_LSB +: 2];
  wire [`EMB_DATA_W-1:0] wdata_pins = full_w ? acc_wdata
       : {acc_wdata[`EMB_NARROW_W-1:0], {`EMB_NARROW_LSB{1'b0}}};
  wire [`EMB_DATA_W-1:0] rdata_pins = full_w ? data_s
       : {{`EMB_NARROW_LSB{1'b0}}, data_s[`EMB_DATA_W-1:`EMB_NARROW_LSB]};

  // ===================================================================
  // Register store for outside masters
  // ===================================================================
  reg            mem_we;
  reg  [IAW-1:0] mem_addr;
  wire [`EMB_DATA_W-1:0] mem_rdata;

  emb_iop_mem #(.AW(IAW), .DW(`EMB_DATA_W)) emb_iop_mem_i
  (
    .sys_clk   (sys_clk),
    .wr_en     (mem_we),
    .wr_addr   (mem_addr),
    .wr_data   (data_s),
    .rd_addr   (mem_addr),
    .rd_data_q (mem_rdata)
  );

  // ===================================================================
  // State
  // ===================================================================
  reg [1:0]       m_state_q;
  reg [2:0]       s_state_q;
  reg [LEN_W-1:0] left_q;
  reg [1:0]       lat_q;
  reg             write_q;
  reg             sync_q;
  reg             float_q;
  reg             rd_prev_q;
  reg             wr_prev_q;
  reg             cnt_ok_q;
  reg [IAW-1:0]   slv_cnt_q;

  wire susp    = ~suspend_bus_tristate_n_s;
  wire m_done  = (m_state_q == M_ACC) & (lat_q == 2'h0) & ack_s & ~susp;
  wire rd_fall = ~rd_s & rd_prev_q;
  wire wr_fall = ~wr_s & wr_prev_q;
  wire iop_hit = (addr_s[`EMB_ADDR_W-1:IAW] == {(`EMB_ADDR_W-IAW){1'b0}});
  wire slv_new = ~is_bus_master & iop_hit & (rd_fall | wr_fall);
  wire [IAW-1:0] slv_addr = (burst_indicator_s & cnt_ok_q) ? slv_cnt_q + 1'b1
                                                : addr_s[IAW-1:0];

  always @*
  begin
    mem_we   = slv_new & ~wr_s & (s_state_q == S_IDLE);
    mem_addr = slv_addr;
  end

  // ===================================================================
  // Master access sequencer
  // ===================================================================
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      m_state_q              <= M_IDLE;
      left_q                 <= {LEN_W{1'b0}};
      lat_q                  <= 2'h0;
      write_q                <= 1'b0;
      sync_q                 <= 1'b0;
      acc_busy_q             <= 1'b0;
      word_take_q            <= 1'b0;
      rdata_valid_q          <= 1'b0;
      rdata_q                <= {`EMB_DATA_W{1'b0}};
      acc_done_q             <= 1'b0;
      addr_o_q               <= {`EMB_ADDR_W{1'b0}};
      memory_bank_select_n_q <= 4'hf;
      rd_n_o_q               <= 1'b1;
      wr_n_o_q               <= 1'b1;
      burst_indicator_o_q    <= 1'b0;
      data_o_q               <= {`EMB_DATA_W{1'b0}};
    end
    else
    begin
      word_take_q   <= 1'b0;
      rdata_valid_q <= 1'b0;
      acc_done_q    <= 1'b0;
      if (lat_q != 2'h0)
      begin
        lat_q <= lat_q - 1'b1;
      end
      case (m_state_q)
        M_IDLE:
        begin
          if (acc_start && is_bus_master && acc_len != {LEN_W{1'b0}})
          begin
            m_state_q              <= M_ACC;
            acc_busy_q             <= 1'b1;
            left_q                 <= acc_len;
            write_q                <= acc_write;
            sync_q                 <= acc_sync;
            lat_q                  <= `EMB_SYNC_LAT;
            addr_o_q               <= acc_addr[`EMB_ADDR_W-1:0];
            memory_bank_select_n_q <= ~(4'h1 << bank);
            rd_n_o_q               <= acc_write;
            wr_n_o_q               <= ~acc_write;
            burst_indicator_o_q    <= 1'b0;
            data_o_q               <= wdata_pins;
            word_take_q            <= acc_write;
          end
          else if (s_state_q == S_WAIT)
          begin
            data_o_q <= mem_rdata;
          end
        end
        M_ACC:
        begin
          // Pins float while suspended, so the answer window restarts on release.
          if (susp)
          begin
            lat_q <= `EMB_SYNC_LAT;
          end
          if (m_done)
          begin
            if (!write_q)
            begin
              rdata_q       <= rdata_pins;
              rdata_valid_q <= 1'b1;
            end
            if (sync_q)
            begin
              memory_bank_select_n_q <= 4'hf;
            end
            if (left_q == {{(LEN_W-1){1'b0}}, 1'b1})
            begin
              m_state_q              <= M_IDLE;
              acc_busy_q             <= 1'b0;
              acc_done_q             <= 1'b1;
              memory_bank_select_n_q <= 4'hf;
              rd_n_o_q               <= 1'b1;
              wr_n_o_q               <= 1'b1;
              burst_indicator_o_q    <= 1'b0;
            end
            else
            begin
              // Address stays put; the slave counts words itself.
              burst_indicator_o_q <= (left_q != {{(LEN_W-2){1'b0}}, 2'h2});
              lat_q               <= `EMB_SYNC_LAT;
              data_o_q            <= wdata_pins;
              word_take_q         <= write_q;
            end
            left_q <= left_q - 1'b1;
          end
        end
        default:
        begin
          m_state_q <= M_IDLE;
        end
      endcase
    end
  end

  // ===================================================================
  // Slave register access and acknowledge
  // ===================================================================
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      s_state_q  <= S_IDLE;
      rd_prev_q  <= 1'b1;
      wr_prev_q  <= 1'b1;
      cnt_ok_q   <= 1'b0;
      slv_cnt_q  <= {IAW{1'b0}};
      ack_o_q    <= 1'b1;
      ack_oe_n_q <= 1'b1;
    end
    else
    begin
      rd_prev_q <= rd_s;
      wr_prev_q <= wr_s;
      if (rd_s && wr_s && !burst_indicator_s)
      begin
        cnt_ok_q <= 1'b0;
      end
      case (s_state_q)
        S_IDLE:
        begin
          ack_o_q    <= 1'b1;
          ack_oe_n_q <= 1'b1;
          if (slv_new)
          begin
            slv_cnt_q <= slv_addr;
            cnt_ok_q  <= 1'b1;
            if (!rd_s)
            begin
              s_state_q  <= S_WAIT;
              ack_o_q    <= 1'b0;
              ack_oe_n_q <= 1'b0;
            end
          end
        end
        S_WAIT:
        begin
          s_state_q <= S_DRIVE;
          ack_o_q   <= 1'b1;
        end
        S_DRIVE:
        begin
          if (rd_s || is_bus_master)
          begin
            s_state_q  <= S_IDLE;
            ack_oe_n_q <= 1'b1;
          end
        end
        default:
        begin
          s_state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ===================================================================
  // Output enables, suspend and slave read data
  // ===================================================================
  reg                   slv_drive_q;

  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      float_q                <= 1'b0;
      addr_oe_n_q            <= 1'b1;
      data_hi_oe_n_q         <= 1'b1;
      data_lo_oe_n_q         <= 1'b1;
      ms_oe_n_q              <= 1'b1;
      rd_n_oe_n_q            <= 1'b1;
      wr_n_oe_n_q            <= 1'b1;
      burst_indicator_oe_n_q <= 1'b1;
      slv_drive_q            <= 1'b0;
    end
    else
    begin
      float_q                <= susp;
      addr_oe_n_q            <= ~is_bus_master | susp;
      ms_oe_n_q              <= ~is_bus_master | susp;
      rd_n_oe_n_q            <= ~is_bus_master | susp;
      wr_n_oe_n_q            <= ~is_bus_master | susp;
      burst_indicator_oe_n_q <= ~is_bus_master | susp;
      slv_drive_q            <= (s_state_q == S_WAIT) | ((s_state_q == S_DRIVE) & ~rd_s);
      if (susp)
      begin
        data_hi_oe_n_q <= 1'b1;
        data_lo_oe_n_q <= 1'b1;
      end
      else if (is_bus_master)
      begin
        data_hi_oe_n_q <= ~((m_state_q == M_ACC) & write_q);
        data_lo_oe_n_q <= ~((m_state_q == M_ACC) & write_q & full_w);
      end
      else
      begin
        data_hi_oe_n_q <= ~slv_drive_q;
        data_lo_oe_n_q <= ~(slv_drive_q & full_w);
      end
    end
  end

  // ===================================================================
  // SDRAM command pins
  // ===================================================================
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      sd_ras_n_q           <= 1'b1;
      sd_cas_n_q           <= 1'b1;
      sd_we_n_q            <= 1'b1;
      sdram_addr_bit_ten_q <= 1'b0;
      sdclk_q              <= 1'b0;
    end
    else
    begin
      sdclk_q <= ~sdclk_q;
      if (sd_cmd_valid && !float_q)
      begin
        {sd_ras_n_q, sd_cas_n_q, sd_we_n_q} <= sd_cmd;
        sdram_addr_bit_ten_q                <= sd_a10;
      end
      else
      begin
        {sd_ras_n_q, sd_cas_n_q, sd_we_n_q} <= `EMB_SD_NOP;
      end
    end
  end

endmodule

//--- rtl/emb_defines.vh
// Constants shared by the external bus port and its register store.
// Assumes inclusion by bare name from files under rtl/.
`ifndef EMB_DEFINES_VH
`define EMB_DEFINES_VH

// =====================================================================
// Widths
// =====================================================================
`define EMB_ADDR_W        24
`define EMB_WADDR_W       28
`define EMB_DATA_W        48
`define EMB_NARROW_W      32
`define EMB_LEN_W         8

// =====================================================================
// Field positions
// =====================================================================
// Upper data pins start here; the low sixteen are shared with links.
`define EMB_NARROW_LSB    16
// Bank number sits above 16M words, or above 64M words for SDRAM.
`define EMB_BANK_LSB      24
`define EMB_BANK_LSB_SDR  26
// Register store is hit when address bits above this are all zero.
`define EMB_IOP_AW        6

// =====================================================================
// Values and reset states
// =====================================================================
`define EMB_PACK_FULL     2'h1
`define EMB_SD_NOP        3'h7
`define EMB_SYNC_LAT      2'h2

`endif

//--- rtl/emb_iop_mem.v
// Small register store reached by outside masters over the bus.
// Assumes one clock; read data appear one edge after the address.
`include "emb_defines.vh"

module emb_iop_mem
#(
  parameter AW = `EMB_IOP_AW,
  parameter DW = `EMB_DATA_W
)
(
  // Clock
  input  wire          sys_clk,
  // Write port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  // Read port
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data_q
);

  reg [DW-1:0] mem_q [0:(1<<AW)-1];

  always @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data_q <= mem_q[rd_addr];
  end

endmodule

//--- verif/emb_port_assertions.sv
// Concurrent checks on the pins of the external bus port.
// Assumes one clock and a synchronous active-low reset.
module emb_port_assertions
#(
  parameter LEN_W = 8
)
(
  // Clock, reset and core request
  input logic             sys_clk, resetn, acc_start, acc_write, acc_sync, acc_sdram,
  input logic [27:0]      acc_addr,
  input logic [LEN_W-1:0] acc_len,
  input logic             acc_busy_q, rdata_valid_q, acc_done_q, is_bus_master,
  // Configuration and SDRAM command
  input logic             link_ports_off, sd_cmd_valid, sd_a10, sd_ras_n_q, sd_cas_n_q,
  input logic             sd_we_n_q, sdram_addr_bit_ten_q,
  input logic [1:0]       instr_packing_field,
  input logic [2:0]       sd_cmd,
  // Pins
  input logic             addr_oe_n_q, data_hi_oe_n_q, data_lo_oe_n_q, ms_oe_n_q, rd_n_i,
  input logic             rd_n_o_q, rd_n_oe_n_q, wr_n_o_q, wr_n_oe_n_q, burst_indicator_o_q,
  input logic             ack_i, ack_o_q, ack_oe_n_q, suspend_bus_tristate_n,
  input logic [3:0]       memory_bank_select_n_q,
  input logic [23:0]      addr_o_q, addr_i
);
  // ==========================================
  // Helper logic
  // ==========================================
  logic [2:0] shi_q;
  logic       sync_q;
  wire        take = acc_start && !acc_busy_q && is_bus_master && acc_len != 0;
  wire        sok = shi_q == 3'h7;
  wire [1:0]  bank = acc_sdram ? acc_addr[27:26] : acc_addr[25:24];
  wire [23:0] pin_addr = acc_addr[23:0];
  wire        full = link_ports_off && instr_packing_field == 2'h1;

  // Suspend must have been high for a while before pin values are judged.
  always @(posedge sys_clk)
  begin
    if (!resetn || !suspend_bus_tristate_n)
      shi_q <= 3'h0;
    else if (!sok)
      shi_q <= shi_q + 3'h1;
    if (take)
      sync_q <= acc_sync;
  end

  // ==========================================
  // Properties
  // ==========================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence ack_pulse;
    ##[2:5] (!ack_o_q && !ack_oe_n_q) ##1 ack_o_q;
  endsequence
  sequence data_phase;
    ##1 (!data_hi_oe_n_q && data_lo_oe_n_q == !full);
  endsequence

  a_read_start: assert property (
    take && !acc_write && sok |=> !rd_n_o_q && !rd_n_oe_n_q && addr_o_q == $past(pin_addr)
    && memory_bank_select_n_q == ~(4'h1 << $past(bank))) else $error("read start wrong");
  a_write_start: assert property (
    take && acc_write && sok |=> (!wr_n_o_q && !wr_n_oe_n_q) ##0 data_phase)
    else $error("write start wrong");
  a_addr_hold: assert property (
    acc_busy_q && $past(acc_busy_q) |-> $stable(addr_o_q)) else $error("burst address moved");
  a_burst_first: assert property (
    take |=> !burst_indicator_o_q) else $error("burst flag on first word");
  a_burst_last: assert property (
    acc_done_q |-> !burst_indicator_o_q) else $error("burst flag on last word");
  a_sync_release: assert property (
    sync_q && rdata_valid_q |=> &memory_bank_select_n_q) else $error("sync select held");
  a_async_hold: assert property (
    !sync_q && acc_busy_q && !acc_done_q && sok |-> memory_bank_select_n_q != 4'hf)
    else $error("async select dropped");
  a_ack_wait: assert property (
    !ack_i [*4] |-> !acc_done_q && !rdata_valid_q) else $error("completed without ack");
  a_susp_float: assert property (
    !suspend_bus_tristate_n [*4] |-> addr_oe_n_q && ms_oe_n_q && rd_n_oe_n_q && wr_n_oe_n_q
    && data_hi_oe_n_q && !acc_done_q) else $error("bus driven under suspend");
  a_slave_ack: assert property (
    !is_bus_master && $fell(rd_n_i) && addr_i[23:6] == 18'h0 |-> ack_pulse)
    else $error("no wait on slave read");
  a_sd_cmd: assert property (
    sd_cmd_valid && sok |=> {sd_ras_n_q, sd_cas_n_q, sd_we_n_q} == $past(sd_cmd)
    && sdram_addr_bit_ten_q == $past(sd_a10)) else $error("sdram command wrong");
  a_slave_quiet: assert property (
    !is_bus_master && !$past(is_bus_master) && !acc_busy_q |-> rd_n_oe_n_q && wr_n_oe_n_q)
    else $error("slave drives strobes");
endmodule

bind emb_port emb_port_assertions #(.LEN_W(LEN_W)) emb_port_assertions_i (
  .sys_clk, .resetn, .acc_start, .acc_write, .acc_sync, .acc_sdram, .acc_addr, .acc_len,
  .acc_busy_q, .rdata_valid_q, .acc_done_q, .is_bus_master, .link_ports_off, .sd_cmd_valid,
  .sd_a10, .sd_ras_n_q, .sd_cas_n_q, .sd_we_n_q, .sdram_addr_bit_ten_q,
  .instr_packing_field, .sd_cmd, .addr_oe_n_q, .data_hi_oe_n_q, .data_lo_oe_n_q,
  .ms_oe_n_q, .rd_n_i, .rd_n_o_q, .rd_n_oe_n_q, .wr_n_o_q, .wr_n_oe_n_q,
  .burst_indicator_o_q, .ack_i, .ack_o_q, .ack_oe_n_q, .suspend_bus_tristate_n,
  .memory_bank_select_n_q, .addr_o_q, .addr_i);

//--- verif/emb_mem_model.sv
// External memory answering the port's own accesses.
// Assumes strobe levels are the resolved wire levels.
module emb_mem_model
(
  // Clock and bus watch; strobes are only observed here
  input  logic        sys_clk, en, rd_n, wr_n, wdata_oe_n,
  input  logic [23:0] addr,
  input  logic [47:0] wdata,
  input  int          wait_n,
  // Answer
  output logic        ack,
  output logic [47:0] data, wr_seen
);
  int  cnt = 0;
  wire act = en && !(rd_n && wr_n);

  initial
  begin
    data = 48'h0;
  end

  // Ack answers once the strobe has been seen for wait_n cycles; idle it rests at its pull-up.
  assign ack = !act || cnt >= wait_n;

  always @(posedge sys_clk)
  begin
    cnt <= act ? cnt + 1 : 0;
    if (act && !rd_n && cnt == 0)
      data <= {addr, ~addr};
    else if (!act)
      data <= ~data;
    if (act && !wr_n && !wdata_oe_n)
      wr_seen <= wdata;
  end
endmodule

//--- verif/emb_port_test.sv
// Self-checking bench for the external bus port.
// Assumes the memory model and the bound checker are compiled alongside.
module emb_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, resetn, acc_start, acc_write, acc_sync, acc_sdram, is_bus_master;
  logic        link_ports_off, sd_cmd_valid, sd_a10, burst_indicator_i, suspend_bus_tristate_n;
  logic        slv, h_rd, h_wr, done;
  logic [1:0]  instr_packing_field;
  logic [2:0]  sd_cmd;
  logic [7:0]  acc_len;
  logic [23:0] addr_i;
  logic [27:0] acc_addr;
  logic [47:0] acc_wdata, sdata, rd;
  wire         acc_busy_q, rdata_valid_q, acc_done_q, sd_ras_n_q, sd_cas_n_q, sd_we_n_q;
  wire         sdram_addr_bit_ten_q, sdclk_q, addr_oe_n_q, data_hi_oe_n_q, data_lo_oe_n_q;
  wire         ms_oe_n_q, rd_n_o_q, rd_n_oe_n_q, wr_n_o_q, wr_n_oe_n_q, burst_indicator_o_q;
  wire         ack_o_q, ack_oe_n_q, mack, word_take_q, burst_indicator_oe_n_q;
  wire [3:0]   memory_bank_select_n_q;
  wire [23:0]  addr_o_q;
  wire [47:0]  rdata_q, data_o_q, mdata, wr_seen;
  wire         rd_n_i = rd_n_oe_n_q ? h_rd : rd_n_o_q;
  wire         wr_n_i = wr_n_oe_n_q ? h_wr : wr_n_o_q;
  wire         ack_i = ack_oe_n_q ? mack : ack_o_q;
  wire [47:0]  data_i = slv ? sdata : mdata;
  int          err_count = 0, compares = 0, wait_n = 1, bcnt, wt;

  emb_port #(.LEN_W(8)) emb_port_i (
    .sys_clk, .resetn, .acc_start, .acc_write, .acc_sync, .acc_sdram, .acc_addr, .acc_len,
    .acc_wdata, .acc_busy_q, .word_take_q, .rdata_valid_q, .rdata_q, .acc_done_q,
    .is_bus_master, .link_ports_off, .instr_packing_field, .sd_cmd_valid, .sd_cmd, .sd_a10,
    .sd_ras_n_q, .sd_cas_n_q, .sd_we_n_q, .sdram_addr_bit_ten_q, .sdclk_q, .addr_i,
    .addr_o_q, .addr_oe_n_q, .data_i, .data_o_q, .data_hi_oe_n_q, .data_lo_oe_n_q,
    .memory_bank_select_n_q, .ms_oe_n_q, .rd_n_i, .rd_n_o_q, .rd_n_oe_n_q, .wr_n_i,
    .wr_n_o_q, .wr_n_oe_n_q, .burst_indicator_i, .burst_indicator_o_q,
    .burst_indicator_oe_n_q, .ack_i, .ack_o_q, .ack_oe_n_q, .suspend_bus_tristate_n);
  emb_mem_model emb_mem_model_i (.sys_clk, .en(is_bus_master), .rd_n(rd_n_i), .wr_n(wr_n_i),
    .wdata_oe_n(data_hi_oe_n_q), .addr(addr_o_q), .wdata(data_o_q), .wait_n, .ack(mack),
    .data(mdata), .wr_seen);

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ==========================================
  // Shared tasks
  // ==========================================
  task automatic tick;
    @(posedge sys_clk);
    #2;
  endtask
  task automatic chk(input bit ok, input string m);
    compares++;
    if (!ok)
    begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic wrap_up;
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic go(input bit w, s, sd, input [27:0] a, input [7:0] n, input [47:0] d);
    {acc_write, acc_sync, acc_sdram, acc_addr, acc_len, acc_wdata} = {w, s, sd, a, n, d};
    acc_start = 1'b1;
    tick;
    acc_start = 1'b0;
  endtask
  task automatic fin;
    done = 1'b0;
    bcnt = 0;
    wt = 0;
    for (int i = 0; i < 300 && !done; i++)
    begin
      bcnt += (burst_indicator_o_q === 1'b1);
      wt += (word_take_q === 1'b1);
      if (rdata_valid_q === 1'b1)
        rd = rdata_q;
      done = (acc_done_q === 1'b1);
      tick;
    end
    if (!done)
    begin
      chk(1'b0, "access timeout");
      wrap_up;
    end
  endtask
  task automatic xfer(input bit w, s, sd, f, input [27:0] a, input [7:0] n, input [47:0] d);
    logic [47:0] p;
    p = {a[23:0], ~a[23:0]};
    link_ports_off = f;
    instr_packing_field = f ? 2'h1 : 2'h0;
    go(w, s, sd, a, n, d);
    fin;
    chk(wt == (w ? n : 0), "write word take count");
    if (w)
      chk(f ? wr_seen === d : wr_seen[47:16] === d[31:0], "write data");
    else
      chk(f ? rd === p : rd[31:0] === p[47:16], "read data");
  endtask

  // ==========================================
  // Scenarios
  // ==========================================
  task automatic s_rw;
    xfer(0, 0, 0, 0, 28'h200_1234, 8'h01, 48'h0);
    xfer(1, 0, 0, 0, 28'h100_0042, 8'h01, 48'h1234_5678_9abc);
    xfer(0, 1, 1, 1, 28'hc00_0777, 8'h01, 48'h0);
    xfer(1, 1, 0, 1, 28'h300_0010, 8'h01, 48'hfedc_ba98_7654);
    chk(bcnt == 0, "burst flag on single word");
  endtask
  task automatic s_burst;
    wait_n = 4;
    xfer(0, 1, 0, 0, 28'h000_0100, 8'h03, 48'h0);
    chk(bcnt > 0, "burst flag missing");
    wait_n = 1;
    xfer(1, 0, 0, 0, 28'h000_0100, 8'h04, 48'h0bad_cafe_0001);
    chk(bcnt > 0, "write burst flag missing");
  endtask
  task automatic s_refuse;
    for (int k = 0; k < 2; k++)
    begin
      {is_bus_master, acc_len} = {k[0], k[0] ? 8'h00 : 8'h01};
      acc_start = 1'b1;
      tick;
      acc_start = 1'b0;
      repeat (4) tick;
      chk(acc_busy_q === 1'b0 && rd_n_i === 1'b1, "refused start opened access");
    end
  endtask
  task automatic s_suspend;
    suspend_bus_tristate_n = 1'b0;
    go(0, 0, 0, 28'h100_0008, 8'h01, 48'h0);
    for (int i = 0; i < 12; i++)
    begin
      chk(acc_done_q !== 1'b1, "done under suspend");
      tick;
    end
    chk({addr_oe_n_q, rd_n_oe_n_q, burst_indicator_oe_n_q} === 3'h7, "bus not floated");
    suspend_bus_tristate_n = 1'b1;
    fin;
    chk(rd[31:0] === 32'h0000_08ff, "read after suspend");
  endtask
  task automatic s_slave;
    bit saw;
    {is_bus_master, link_ports_off, instr_packing_field, slv} = 5'h0b;
    {addr_i, sdata} = {24'h00_0005, 48'h5a5a_1234_c3c3};
    h_wr = 1'b0;
    repeat (6) tick;
    {h_wr, burst_indicator_i} = 2'h3;
    repeat (3) tick;
    {h_wr, sdata} = {1'b0, 48'h0f0f_8765_4321};
    repeat (6) tick;
    {h_wr, burst_indicator_i, addr_i} = {2'h2, 24'h00_0006};
    repeat (3) tick;
    sdata = ~sdata;
    h_rd = 1'b0;
    saw = 1'b0;
    for (int i = 0; i < 20 && data_hi_oe_n_q !== 1'b0; i++)
    begin
      saw |= (ack_o_q === 1'b0 && ack_oe_n_q === 1'b0);
      tick;
    end
    chk(saw, "no wait state on slave read");
    chk(data_o_q === 48'h0f0f_8765_4321, "register read back");
    h_rd = 1'b1;
    addr_i = 24'h00_0040;
    repeat (4) tick;
    h_rd = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      chk(ack_oe_n_q === 1'b1, "ack for unmapped place");
      tick;
    end
    h_rd = 1'b1;
    repeat (4) tick;
    {slv, is_bus_master} = 2'h1;
    tick;
  endtask
  task automatic s_sdram;
    logic k;
    sd_cmd_valid = 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      {sd_cmd, sd_a10} = {c[2:0], c[0]};
      k = sdclk_q;
      tick;
      chk({sd_ras_n_q, sd_cas_n_q, sd_we_n_q, sdram_addr_bit_ten_q} === {c[2:0], c[0]},
        "sdram command");
      chk(sdclk_q !== k, "sdram clock stuck");
    end
    sd_cmd_valid = 1'b0;
    tick;
    chk({sd_ras_n_q, sd_cas_n_q, sd_we_n_q} === 3'h7, "idle command");
  endtask

  initial
  begin
    {acc_start, acc_write, acc_sync, acc_sdram, sd_cmd_valid, sd_a10, slv} = 7'h00;
    {link_ports_off, burst_indicator_i, resetn, instr_packing_field} = 5'h00;
    {is_bus_master, h_rd, h_wr, suspend_bus_tristate_n} = 4'hf;
    {acc_addr, acc_len, acc_wdata, addr_i, sdata} = '0;
    sd_cmd = 3'h7;
    repeat (10) @(posedge sys_clk);
    #2;
    resetn = 1'b1;
    tick;
    s_rw;
    s_burst;
    s_refuse;
    s_suspend;
    s_slave;
    s_sdram;
    wrap_up;
  end
endmodule
